// ===== design/pmm_defines.svh
// Constants for the management serial port: field codes, register numbers and counts.
`ifndef PMM_DEFINES_SVH
`define PMM_DEFINES_SVH

`define PMM_OP_READ      2'h2
`define PMM_OP_WRITE     2'h1
`define PMM_INIT_LAST    4'h1
`define PMM_TWO_LAST     4'h1
`define PMM_FIVE_LAST    4'h4
`define PMM_DATA_LAST    4'hF
`define PMM_REG_MMD_CTL  5'h0D
`define PMM_REG_MMD_DAT  5'h0E
`define PMM_REG_IMASK    5'h19
`define PMM_REG_ISTAT    5'h1A
`define PMM_REG_PAGE     5'h1F
`define PMM_PAGE_LSB     0
`define PMM_IRQ_PIN_EN   15
`define PMM_MMD_FN_HI    15
`define PMM_MMD_FN_LO    14
`define PMM_MMD_FN_ADDR  2'h0
`define PMM_MMD_IDX_HI   3
`define PMM_PORT1_OFS    5'h01
`define PMM_PAGE0        1'h0
`define PMM_WORD_ZERO    16'h0000

`endif

// ===== design/pmm_pkg.sv
// Types shared by the management serial port modules.
package pmm_pkg;

	typedef enum logic [3:0] {
		PMM_ST_INIT,
		PMM_ST_IDLE,
		PMM_ST_START,
		PMM_ST_OP,
		PMM_ST_PHYAD,
		PMM_ST_REGAD,
		PMM_ST_TA,
		PMM_ST_DATA,
		PMM_ST_IGNORE
	} pmm_state_t;

	typedef struct packed {
		logic [1:0] op;
		logic       port;
		logic       match;
		logic [4:0] regad;
	} pmm_frame_t;

endpackage : pmm_pkg

// ===== design/pmm_sync.sv
// Two-flop synchroniser for levels entering the core clock domain.
`timescale 1ns/1ps
module pmm_sync
	import pmm_pkg::*;
#(
	parameter int WIDTH = 1
) (
	input  wire logic             core_clk,
	input  wire logic             arst_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_r   <= '0;
			sync_out <= '0;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule : pmm_sync

// ===== design/pmm_irq.sv
// Sticky interrupt status and open-drain pin enable for one port.
`timescale 1ns/1ps
`include "pmm_defines.svh"
module pmm_irq
	import pmm_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	input  wire logic [15:0] event_lvl,
	input  wire logic        pin_en,
	input  wire logic        rd_clr,
	output logic      [15:0] status,
	output logic             irq_oe_n
);

	logic [15:0] event_d_r;
	logic [15:0] event_rise;
	logic [15:0] status_r;
	logic [15:0] status_nxt;
	logic        irq_oe_n_r;

	assign event_rise = event_lvl & ~event_d_r;
	// A new event in the clearing cycle survives the clear.
	assign status_nxt = (rd_clr ? `PMM_WORD_ZERO : status_r) | event_rise;
	assign status     = status_r;
	assign irq_oe_n   = irq_oe_n_r;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			event_d_r  <= '0;
			status_r   <= '0;
			irq_oe_n_r <= 1'b1;
		end else begin
			event_d_r  <= event_lvl;
			status_r   <= status_nxt;
			irq_oe_n_r <= ~(pin_en && (status_nxt != `PMM_WORD_ZERO));
		end
	end

	a_irq_held_pending: assert property (@(posedge core_clk) disable iff (!arst_n)
		(status_r != `PMM_WORD_ZERO) && pin_en && !rd_clr ##1 pin_en |-> !irq_oe_n)
		else $error("interrupt released while status pending");

	a_irq_pin_gated: assert property (@(posedge core_clk) disable iff (!arst_n)
		!pin_en |=> irq_oe_n)
		else $error("interrupt driven while pin enable clear");

	a_irq_read_clears: assert property (@(posedge core_clk) disable iff (!arst_n)
		rd_clr && (event_rise == `PMM_WORD_ZERO) |=> (status_r == `PMM_WORD_ZERO))
		else $error("status not cleared by read");

endmodule : pmm_irq

// ===== design/pmm_mdio_port.sv
// Management serial port target: frame decoder, paged register bank and port interrupts.
// Functional notes
// - Sample data bits on clock rising edge.
// - Drive returned bits on clock rising edge.
// - Frames are 32 bits, optional preamble.
// - Idle line is released and pulled high.
// - Accept no preamble, or any length; after reset the code waits for two one bits before the first frame.
// - Bad start pattern ignored until preamble; the code returns to idle on the first one bit.
// - Opcode 10 reads, 01 writes, else ignore.
// - Act only on matching five-bit address.
// - Next five bits select the register.
// - Device drives second turnaround bit low.
// - Read data bits held edge to edge.
// - Thirty-two registers, register 31 selects page.
// - Registers 13 and 14 reach extended space.
// - Per-port interrupt pulls low when enabled.
// - Interrupt pins open-drain, never drive high.
// - Reading status returns, clears, releases interrupt.
// - Interrupt held until status is cleared.
`timescale 1ns/1ps
`include "pmm_defines.svh"
module pmm_mdio_port
	import pmm_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	input  wire logic        mdc,
	input  wire logic        mdio_in,
	output logic             mdio_out,
	output logic             mdio_oe_n,
	input  wire logic [4:0]  phy_addr,
	input  wire logic [15:0] port0_event,
	input  wire logic [15:0] port1_event,
	input  wire logic        port0_irq_n_in,
	output logic             port0_irq_n_out,
	output logic             port0_irq_n_oe_n,
	input  wire logic        port1_irq_n_in,
	output logic             port1_irq_n_out,
	output logic             port1_irq_n_oe_n
);

	logic [6:0]  sync_q;
	logic        mdc_s;
	logic        bit_in;
	logic [4:0]  phy_base;
	logic        mdc_d_r;
	logic        mdc_rise;

	pmm_sync #(.WIDTH(7)) u_sync (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.async_in ({mdc, mdio_in, phy_addr}),
		.sync_out (sync_q)
	);

	assign mdc_s    = sync_q[6];
	assign bit_in   = sync_q[5];
	assign phy_base = sync_q[4:0];
	assign mdc_rise = mdc_s & ~mdc_d_r;

	pmm_state_t  state_r;
	pmm_state_t  state_nxt;
	logic [3:0]  cnt_r;
	logic [3:0]  cnt_nxt;
	pmm_frame_t  frame_r;
	pmm_frame_t  frame_nxt;
	logic [15:0] shift_r;
	logic [15:0] shift_in;
	logic        hit0;
	logic        hit1;
	logic        is_read;
	logic        is_write;

	assign shift_in = {shift_r[14:0], bit_in};
	assign hit0     = (shift_in[4:0] == phy_base);
	assign hit1     = (shift_in[4:0] == phy_base + `PMM_PORT1_OFS);
	assign is_read  = frame_r.match && (frame_r.op == `PMM_OP_READ);
	assign is_write = frame_r.match && (frame_r.op == `PMM_OP_WRITE);

	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		frame_nxt = frame_r;
		if (mdc_rise) begin
			cnt_nxt = cnt_r + 4'h1;
			case (state_r)
				PMM_ST_INIT: begin
					cnt_nxt = bit_in ? cnt_r + 4'h1 : 4'h0;
					if (bit_in && cnt_r == `PMM_INIT_LAST) begin
						state_nxt = PMM_ST_IDLE;
					end
				end
				PMM_ST_IDLE: begin
					cnt_nxt = 4'h0;
					if (!bit_in) begin
						state_nxt = PMM_ST_START;
					end
				end
				PMM_ST_START: begin
					cnt_nxt   = 4'h0;
					state_nxt = bit_in ? PMM_ST_OP : PMM_ST_IGNORE;
				end
				PMM_ST_OP: begin
					if (cnt_r == `PMM_TWO_LAST) begin
						cnt_nxt      = 4'h0;
						frame_nxt.op = shift_in[1:0];
						if (shift_in[1:0] == `PMM_OP_READ || shift_in[1:0] == `PMM_OP_WRITE) begin
							state_nxt = PMM_ST_PHYAD;
						end else begin
							state_nxt = PMM_ST_IGNORE;
						end
					end
				end
				PMM_ST_PHYAD: begin
					if (cnt_r == `PMM_FIVE_LAST) begin
						cnt_nxt         = 4'h0;
						frame_nxt.match = hit0 | hit1;
						frame_nxt.port  = ~hit0;
						state_nxt       = PMM_ST_REGAD;
					end
				end
				PMM_ST_REGAD: begin
					if (cnt_r == `PMM_FIVE_LAST) begin
						cnt_nxt         = 4'h0;
						frame_nxt.regad = shift_in[4:0];
						state_nxt       = PMM_ST_TA;
					end
				end
				PMM_ST_TA: begin
					if (cnt_r == `PMM_TWO_LAST) begin
						cnt_nxt   = 4'h0;
						state_nxt = PMM_ST_DATA;
					end
				end
				PMM_ST_DATA: begin
					if (cnt_r == `PMM_DATA_LAST) begin
						cnt_nxt   = 4'h0;
						state_nxt = PMM_ST_IDLE;
					end
				end
				PMM_ST_IGNORE: begin
					cnt_nxt = 4'h0;
					if (bit_in) begin
						state_nxt = PMM_ST_IDLE;
					end
				end
				default: begin
					cnt_nxt   = 4'h0;
					state_nxt = PMM_ST_INIT;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			mdc_d_r <= 1'b0;
			state_r <= PMM_ST_INIT;
			cnt_r   <= 4'h0;
			frame_r <= '0;
			shift_r <= '0;
		end else begin
			mdc_d_r <= mdc_s;
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			frame_r <= frame_nxt;
			shift_r <= mdc_rise ? shift_in : shift_r;
		end
	end

	// Register bank: two ports, two pages of 32 words each, plus the extended space.
	logic [15:0] regs_r [0:127];
	logic [15:0] eee_r [0:31];
	logic [15:0] page_r [0:1];
	logic [15:0] mmd_ctl_r [0:1];
	logic [15:0] mmd_addr_r [0:1];
	logic [15:0] istat [0:1];
	logic        p;
	logic [6:0]  mem_idx;
	logic [4:0]  eee_idx;
	logic        mmd_is_addr;
	logic [15:0] mmd_rd;
	logic [15:0] rd_word;
	logic        wr_fire;
	logic        rd_fire;
	logic        wr_plain;

	assign p           = frame_r.port;
	assign mem_idx     = {p, page_r[p][`PMM_PAGE_LSB], frame_r.regad};
	assign eee_idx     = {p, mmd_addr_r[p][`PMM_MMD_IDX_HI:0]};
	assign mmd_is_addr = (mmd_ctl_r[p][`PMM_MMD_FN_HI:`PMM_MMD_FN_LO] == `PMM_MMD_FN_ADDR);
	assign mmd_rd      = mmd_is_addr ? mmd_addr_r[p] : eee_r[eee_idx];
	assign rd_word     = (frame_r.regad == `PMM_REG_PAGE)    ? page_r[p] :
	                     (frame_r.regad == `PMM_REG_ISTAT)   ? istat[p] :
	                     (frame_r.regad == `PMM_REG_MMD_CTL) ? mmd_ctl_r[p] :
	                     (frame_r.regad == `PMM_REG_MMD_DAT) ? mmd_rd : regs_r[mem_idx];
	assign wr_fire     = mdc_rise && state_r == PMM_ST_DATA && cnt_r == `PMM_DATA_LAST && is_write;
	assign rd_fire     = mdc_rise && state_r == PMM_ST_TA && cnt_r == `PMM_TWO_LAST && is_read;
	assign wr_plain    = wr_fire && frame_r.regad != `PMM_REG_PAGE
	                     && frame_r.regad != `PMM_REG_ISTAT
	                     && frame_r.regad != `PMM_REG_MMD_CTL
	                     && frame_r.regad != `PMM_REG_MMD_DAT;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			regs_r     <= '{default: `PMM_WORD_ZERO};
			eee_r      <= '{default: `PMM_WORD_ZERO};
			page_r     <= '{default: `PMM_WORD_ZERO};
			mmd_ctl_r  <= '{default: `PMM_WORD_ZERO};
			mmd_addr_r <= '{default: `PMM_WORD_ZERO};
		end else if (wr_fire) begin
			case (frame_r.regad)
				`PMM_REG_PAGE: begin
					page_r[p] <= shift_in;
				end
				`PMM_REG_ISTAT: begin
				end
				`PMM_REG_MMD_CTL: begin
					mmd_ctl_r[p] <= shift_in;
				end
				`PMM_REG_MMD_DAT: begin
					if (mmd_is_addr) begin
						mmd_addr_r[p] <= shift_in;
					end else begin
						eee_r[eee_idx] <= shift_in;
					end
				end
				default: begin
					regs_r[mem_idx] <= shift_in;
				end
			endcase
		end
	end

	// Read data path; the line is only driven during a matched read.
	logic [15:0] rd_shift_r;
	logic        mdio_out_r;
	logic        mdio_oe_n_r;
	logic        ta_drive;
	logic        data_more;
	logic        data_end;

	assign ta_drive  = mdc_rise && state_r == PMM_ST_TA && cnt_r == 4'h0 && is_read;
	assign data_more = mdc_rise && state_r == PMM_ST_DATA && cnt_r != `PMM_DATA_LAST && is_read;
	assign data_end  = mdc_rise && state_r == PMM_ST_DATA && cnt_r == `PMM_DATA_LAST;
	assign mdio_out  = mdio_out_r;
	assign mdio_oe_n = mdio_oe_n_r;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_shift_r  <= '0;
			mdio_out_r  <= 1'b0;
			mdio_oe_n_r <= 1'b1;
		end else if (ta_drive) begin
			mdio_out_r  <= 1'b0;
			mdio_oe_n_r <= 1'b0;
		end else if (rd_fire) begin
			mdio_out_r <= rd_word[15];
			rd_shift_r <= {rd_word[14:0], 1'b0};
		end else if (data_more) begin
			mdio_out_r <= rd_shift_r[15];
			rd_shift_r <= {rd_shift_r[14:0], 1'b0};
		end else if (data_end) begin
			mdio_oe_n_r <= 1'b1;
		end
	end

	// Interrupts; the status word of the read is captured before it clears.
	logic [1:0] rd_clr;

	assign rd_clr[0]        = rd_fire && frame_r.regad == `PMM_REG_ISTAT && !p;
	assign rd_clr[1]        = rd_fire && frame_r.regad == `PMM_REG_ISTAT && p;
	assign port0_irq_n_out  = 1'b0;
	assign port1_irq_n_out  = 1'b0;

	pmm_irq u_irq0 (
		.core_clk  (core_clk),
		.arst_n    (arst_n),
		.event_lvl (port0_event),
		.pin_en    (regs_r[{1'b0, `PMM_PAGE0, `PMM_REG_IMASK}][`PMM_IRQ_PIN_EN]),
		.rd_clr    (rd_clr[0]),
		.status    (istat[0]),
		.irq_oe_n  (port0_irq_n_oe_n)
	);

	pmm_irq u_irq1 (
		.core_clk  (core_clk),
		.arst_n    (arst_n),
		.event_lvl (port1_event),
		.pin_en    (regs_r[{1'b1, `PMM_PAGE0, `PMM_REG_IMASK}][`PMM_IRQ_PIN_EN]),
		.rd_clr    (rd_clr[1]),
		.status    (istat[1]),
		.irq_oe_n  (port1_irq_n_oe_n)
	);

	// Helper state that only the checks below read.
	logic        chk_wr_r;
	logic [6:0]  chk_idx_r;
	logic [15:0] chk_dat_r;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			chk_wr_r  <= 1'b0;
			chk_idx_r <= '0;
			chk_dat_r <= '0;
		end else begin
			chk_wr_r  <= wr_plain;
			chk_idx_r <= mem_idx;
			chk_dat_r <= shift_in;
		end
	end

	sequence s_read_ta;
		ta_drive;
	endsequence

	a_sample_on_rise: assert property (@(posedge core_clk) disable iff (!arst_n)
		(state_r != $past(state_r)) |-> $past(mdc_rise))
		else $error("frame state moved without clock rising edge");

	a_out_on_rise: assert property (@(posedge core_clk) disable iff (!arst_n)
		$changed(mdio_out_r) |-> $past(mdc_rise))
		else $error("line data changed without clock rising edge");

	a_ta_drives_low: assert property (@(posedge core_clk) disable iff (!arst_n)
		s_read_ta |=> (!mdio_oe_n && !mdio_out) [*3])
		else $error("second turnaround bit not driven low");

	a_drive_only_read: assert property (@(posedge core_clk) disable iff (!arst_n)
		!mdio_oe_n |-> is_read && (state_r == PMM_ST_TA || state_r == PMM_ST_DATA
		|| state_r == PMM_ST_IDLE))
		else $error("line driven outside a matched read");

	a_release_after: assert property (@(posedge core_clk) disable iff (!arst_n)
		data_end |=> mdio_oe_n)
		else $error("line not released after last data bit");

	a_bad_start: assert property (@(posedge core_clk) disable iff (!arst_n)
		mdc_rise && state_r == PMM_ST_START && !bit_in |=> state_r == PMM_ST_IGNORE)
		else $error("bad start pattern not ignored");

	a_bad_opcode: assert property (@(posedge core_clk) disable iff (!arst_n)
		mdc_rise && state_r == PMM_ST_OP && cnt_r == `PMM_TWO_LAST
		&& shift_in[1:0] != `PMM_OP_READ && shift_in[1:0] != `PMM_OP_WRITE
		|=> state_r == PMM_ST_IGNORE)
		else $error("bad opcode not ignored");

	a_write_loads: assert property (@(posedge core_clk) disable iff (!arst_n)
		chk_wr_r |-> regs_r[chk_idx_r] == chk_dat_r)
		else $error("write data not loaded into register");

endmodule : pmm_mdio_port

// ===== verif/pmm_mgr_model.sv
// Station manager model: drives the management clock and data line one bit at a time.
`timescale 1ns/1ps
module pmm_mgr_model (
	input  wire logic core_clk,
	input  wire logic line,
	output logic      mdc,
	output logic      mgr_oe,
	output logic      mgr_bit
);
	initial begin
		mdc = 1'b0;
		mgr_oe = 1'b0;
		mgr_bit = 1'b1;
	end

	// Data changes while the clock is low; the line is sampled just before the clock rises.
	task automatic bit_cycle(input logic drv, input logic b, output logic seen);
		mgr_oe <= drv;
		mgr_bit <= b;
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		seen = line;
		@(posedge core_clk);
		mdc <= 1'b1;
		repeat (4) @(posedge core_clk);
		mdc <= 1'b0;
	endtask : bit_cycle

	task automatic frame(input int pre, input logic [1:0] st, input logic [1:0] op,
		input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] wd,
		output logic ta2, output logic [15:0] rd);
		logic        rdn;
		logic        s;
		logic [13:0] hd;
		rdn = (st == 2'h1) && (op == 2'h2);
		hd = {st, op, pa, ra};
		repeat (pre) bit_cycle(1'b1, 1'b1, s);
		for (int i = 13; i >= 0; i--) bit_cycle(1'b1, hd[i], s);
		bit_cycle(!rdn, 1'b1, s);
		bit_cycle(!rdn, 1'b0, ta2);
		for (int i = 15; i >= 0; i--) begin
			bit_cycle(!rdn, wd[i], s);
			rd[i] = s;
		end
		mgr_oe <= 1'b0;
		@(posedge core_clk);
	endtask : frame
endmodule : pmm_mgr_model

// ===== verif/phy_mdio_management_port_tb.sv
// Self-checking bench for the management serial port target.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
	$display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module phy_mdio_management_port_tb;
	import pmm_pkg::*;
	logic        core_clk;
	logic        arst_n;
	logic        mdc;
	logic        mgr_oe;
	logic        mgr_bit;
	logic        line;
	logic        mdio_out;
	logic        mdio_oe_n;
	logic [4:0]  phy_addr;
	logic [15:0] port0_event;
	logic [15:0] port1_event;
	logic        p0_out;
	logic        p0_oe_n;
	logic        p1_out;
	logic        p1_oe_n;
	logic        p0_pin;
	logic        p1_pin;
	int          err_total;
	int          compares;

	assign line = !mdio_oe_n ? mdio_out : (mgr_oe ? mgr_bit : 1'b1);
	assign p0_pin = p0_oe_n ? 1'b1 : p0_out;
	assign p1_pin = p1_oe_n ? 1'b1 : p1_out;

	pmm_mdio_port DUT (
		.core_clk(core_clk), .arst_n(arst_n), .mdc(mdc), .mdio_in(line),
		.mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .phy_addr(phy_addr),
		.port0_event(port0_event), .port1_event(port1_event),
		.port0_irq_n_in(p0_pin), .port0_irq_n_out(p0_out), .port0_irq_n_oe_n(p0_oe_n),
		.port1_irq_n_in(p1_pin), .port1_irq_n_out(p1_out), .port1_irq_n_oe_n(p1_oe_n)
	);

	pmm_mgr_model mgr (
		.core_clk(core_clk), .line(line), .mdc(mdc), .mgr_oe(mgr_oe), .mgr_bit(mgr_bit)
	);

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	task automatic give_verdict;
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : give_verdict

	task automatic wr(input int pre, input logic [4:0] pa, input logic [4:0] ra,
		input logic [15:0] d);
		logic        t;
		logic [15:0] q;
		mgr.frame(pre, 2'h1, 2'h1, pa, ra, d, t, q);
	endtask : wr

	task automatic rd(input int pre, input logic [4:0] pa, input logic [4:0] ra,
		input logic [15:0] e, input string nm);
		logic        t;
		logic [15:0] d;
		mgr.frame(pre, 2'h1, 2'h2, pa, ra, 16'h0000, t, d);
		`CHK({nm, " turnaround"}, 1'b0, t)
		`CHK(nm, e, d)
		repeat (5) @(posedge core_clk);
		`CHK({nm, " release"}, 1'b1, mdio_oe_n)
	endtask : rd

	task automatic t_reset;
		logic s;
		`CHK("oe after reset", 1'b1, mdio_oe_n)
		`CHK("irq0 after reset", 1'b1, p0_oe_n)
		mgr.bit_cycle(1'b1, 1'b1, s);
		mgr.bit_cycle(1'b1, 1'b1, s);
		rd(0, 5'h04, 5'h00, 16'h0000, "reg0 reset");
		$display("t_reset done");
	endtask : t_reset

	task automatic t_rw;
		wr(0, 5'h04, 5'h00, 16'hA5C3);
		rd(0, 5'h04, 5'h00, 16'hA5C3, "reg0");
		wr(1, 5'h04, 5'h1E, 16'hFFFF);
		rd(32, 5'h04, 5'h1E, 16'hFFFF, "reg30");
		$display("t_rw done");
	endtask : t_rw

	task automatic t_bad;
		logic [3:0]  bad[4];
		logic        t;
		logic [15:0] q;
		bad = '{4'h1, 4'h9, 4'h4, 4'h7};
		wr(0, 5'h04, 5'h00, 16'h1234);
		foreach (bad[i]) mgr.frame(0, bad[i][3:2], bad[i][1:0], 5'h04, 5'h00, 16'h0000, t, q);
		rd(2, 5'h04, 5'h00, 16'h1234, "after bad frames");
		$display("t_bad done");
	endtask : t_bad

	task automatic t_addr;
		logic        t;
		logic [15:0] q;
		wr(0, 5'h06, 5'h00, 16'h9999);
		mgr.frame(0, 2'h1, 2'h2, 5'h06, 5'h00, 16'h0000, t, q);
		`CHK("foreign turnaround", 1'b1, t)
		`CHK("foreign data", 16'hFFFF, q)
		wr(0, 5'h05, 5'h00, 16'h0F0F);
		rd(0, 5'h04, 5'h00, 16'h1234, "port0 reg0");
		rd(0, 5'h05, 5'h00, 16'h0F0F, "port1 reg0");
		$display("t_addr done");
	endtask : t_addr

	task automatic t_page;
		wr(0, 5'h04, 5'h05, 16'h1111);
		wr(0, 5'h04, 5'h1F, 16'h0001);
		wr(0, 5'h04, 5'h05, 16'h2222);
		rd(0, 5'h04, 5'h1F, 16'h0001, "page select");
		wr(0, 5'h04, 5'h1F, 16'h0000);
		rd(0, 5'h04, 5'h05, 16'h1111, "page0 reg5");
		wr(0, 5'h04, 5'h1F, 16'h0001);
		rd(0, 5'h04, 5'h05, 16'h2222, "page1 reg5");
		wr(0, 5'h04, 5'h1F, 16'h0000);
		$display("t_page done");
	endtask : t_page

	task automatic t_ext;
		logic [15:0] seq[14];
		seq = '{16'h0000, 16'h0003, 16'h4000, 16'hABCD, 16'h0000, 16'h0005, 16'h4000,
			16'h1357, 16'h0000, 16'h0003, 16'h4000, 16'h0, 16'h0, 16'h0};
		for (int i = 0; i < 11; i++) wr(0, 5'h04, (i % 2 == 0) ? 5'h0D : 5'h0E, seq[i]);
		rd(0, 5'h04, 5'h0E, 16'hABCD, "extended word 3");
		wr(0, 5'h04, 5'h0D, 16'h0000);
		rd(0, 5'h04, 5'h0E, 16'h0003, "address latch");
		$display("t_ext done");
	endtask : t_ext

	task automatic t_irq;
		@(posedge core_clk);
		port0_event <= 16'h0200;
		repeat (3) @(posedge core_clk);
		`CHK("irq0 pin disabled", 1'b1, p0_oe_n)
		wr(0, 5'h04, 5'h19, 16'h8000);
		repeat (3) @(posedge core_clk);
		`CHK("irq0 asserted", 1'b0, p0_oe_n)
		`CHK("irq0 drive level", 1'b0, p0_out)
		`CHK("irq1 idle", 1'b1, p1_oe_n)
		port0_event <= 16'h0004;
		repeat (3) @(posedge core_clk);
		port0_event <= 16'h0000;
		repeat (3) @(posedge core_clk);
		`CHK("irq0 held", 1'b0, p0_oe_n)
		rd(0, 5'h04, 5'h1A, 16'h0204, "status0");
		`CHK("irq0 cleared", 1'b1, p0_oe_n)
		wr(0, 5'h04, 5'h1A, 16'hFFFF);
		rd(0, 5'h04, 5'h1A, 16'h0000, "status0 again");
		wr(0, 5'h05, 5'h19, 16'h8000);
		port1_event <= 16'h0001;
		repeat (3) @(posedge core_clk);
		`CHK("irq1 asserted", 1'b0, p1_oe_n)
		`CHK("irq1 drive level", 1'b0, p1_out)
		`CHK("irq0 quiet", 1'b1, p0_oe_n)
		rd(0, 5'h05, 5'h1A, 16'h0001, "status1");
		`CHK("irq1 cleared", 1'b1, p1_oe_n)
		$display("t_irq done");
	endtask : t_irq

	initial begin
		err_total = 0;
		compares = 0;
		arst_n = 1'b0;
		phy_addr = 5'h04;
		port0_event = 16'h0000;
		port1_event = 16'h0000;
		repeat (5) @(posedge core_clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		t_reset;
		t_rw;
		t_bad;
		t_addr;
		t_page;
		t_ext;
		t_irq;
		give_verdict;
	end

	initial begin
		repeat (60000) @(posedge core_clk);
		err_total++;
		give_verdict;
	end
endmodule : phy_mdio_management_port_tb
